// ===== rtl/awg_run_pkg.sv
// Shared constants and types for the run, arm and trigger controller
package awg_run_pkg;
   // Register port widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int LOOP_W = 20;
   localparam int IDLE_W = 16;
   // Register byte addresses
   localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] A_IDLE = 8'h04;
   localparam logic [ADDR_W-1:0] A_WLOOP = 8'h08;
   localparam logic [ADDR_W-1:0] A_SLOOP = 8'h0c;
   localparam logic [ADDR_W-1:0] A_CMD = 8'h10;
   localparam logic [ADDR_W-1:0] A_STAT = 8'h14;
   // Control register field positions
   localparam int CTL_TRIG = 0;
   localparam int CTL_ARMED = 1;
   localparam int CTL_FUNC = 2;
   localparam int CTL_ADV = 5;
   localparam int CTL_ENSRC = 7;
   localparam int CTL_INSRC = 9;
   localparam int CTL_ABT_BUS = 11;
   localparam int CTL_POL = 12;
   localparam int CTL_EVT_FALL = 14;
   localparam int CTL_SMART = 15;
   localparam int CTL_OUT_ON = 16;
   localparam int CTL_JUMP = 17;
   // Command register bit positions (write-only pulses)
   localparam int CMD_EN = 0;
   localparam int CMD_TRIG = 1;
   localparam int CMD_ABORT = 2;
   // Output function codes
   localparam logic [2:0] FN_STD = 3'h0;
   localparam logic [2:0] FN_ARB = 3'h1;
   localparam logic [2:0] FN_SEQ = 3'h2;
   localparam logic [2:0] FN_ADV = 3'h3;
   localparam logic [2:0] FN_MOD = 3'h4;
   localparam logic [2:0] FN_PULSE = 3'h5;
   // Advance mode codes
   localparam logic [1:0] ADV_AUTO = 2'h0;
   localparam logic [1:0] ADV_ONCE = 2'h1;
   localparam logic [1:0] ADV_STEP = 2'h2;
   // Enable source codes, continuous mode
   localparam logic [1:0] EN_TRIG = 2'h0;
   localparam logic [1:0] EN_EVENT = 2'h1;
   localparam logic [1:0] EN_BUS = 2'h2;
   // Initiate source codes, triggered mode
   localparam logic [1:0] IN_PANEL = 2'h0;
   localparam logic [1:0] IN_EVENT = 2'h1;
   localparam logic [1:0] IN_TRIG = 2'h2;
   localparam logic [1:0] IN_BUS = 2'h3;
   // Trigger polarity codes
   localparam logic [1:0] POL_RISE = 2'h0;
   localparam logic [1:0] POL_FALL = 2'h1;
   localparam logic [1:0] POL_BOTH = 2'h2;
   // Reset values and loop limits
   localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
   localparam logic [IDLE_W-1:0] IDLE_RST = 16'h0000;
   localparam logic [LOOP_W-1:0] LOOP_MIN = 20'h00001;
   localparam logic [LOOP_W-1:0] LOOP_MAX = 20'hf4240;
   // Fixed start latency
   localparam int CLK_NS = 50;
   localparam int SYS_DELAY_NS = 100;
   localparam int SYS_DELAY_CYC = (SYS_DELAY_NS + CLK_NS - 1) / CLK_NS;
   // Run state machine
   typedef enum logic [2:0] {ST_OFF, ST_IDLE, ST_RUN, ST_HOLD, ST_JUMP}
      run_state_e;
endpackage : awg_run_pkg

// ===== rtl/awg_edge_detect.sv
// Polarity-programmable transition detector for one input line
`timescale 1ns/1ps
`default_nettype none
module awg_edge_detect (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_srst,
   // Line and sense selection
   input wire logic i_level,
   input wire logic i_rise_en,
   input wire logic i_fall_en,
   // Detected transition
   output logic o_pulse
);
   logic last_ff; // Previous sample of the line
   logic rise; // Low to high seen
   logic fall; // High to low seen

   assign rise = i_level & ~last_ff;
   assign fall = ~i_level & last_ff;
   assign o_pulse = (rise & i_rise_en) | (fall & i_fall_en);

   // Keep last level; reset low so a high line reads as a rise
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
         last_ff <= 1'b0;
      else
         last_ff <= i_level;
   end
endmodule : awg_edge_detect
`default_nettype wire

// ===== rtl/awg_run_ctrl.sv
// Run mode, arming, trigger source and loop control for the generator
`timescale 1ns/1ps
`default_nettype none
module awg_run_ctrl
   import awg_run_pkg::*;
#(
   parameter int LAT_CYC = SYS_DELAY_CYC
)(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_srst,
   // Register port
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [DATA_W-1:0] o_rdata,
   // Front panel
   input wire logic i_panel_self_arm,
   input wire logic i_manual_trigger_button,
   input wire logic i_panel_abort,
   // External trigger and event lines
   input wire logic i_trig_in,
   input wire logic i_event_in,
   // Waveform engine progress
   input wire logic i_wave_end,
   input wire logic i_seq_end,
   // Waveform engine control
   output logic o_gen_run,
   output logic o_hold_last,
   output logic o_idle_active,
   output logic [IDLE_W-1:0] o_idle_level,
   output logic o_wave_restart,
   output logic o_step_adv,
   output logic o_smart_permit
);
   // Software registers
   logic [DATA_W-1:0] ctrl_ff; // Mode, sources and options
   logic [IDLE_W-1:0] idle_ff; // Idle DC level
   logic [LOOP_W-1:0] wloop_ff; // Segment loops or burst count
   logic [LOOP_W-1:0] sloop_ff; // Sequence loops
   // Controller state
   run_state_e state_ff; // Run state
   run_state_e nxt_state; // Next run state
   logic [LAT_CYC-1:0] lat_ff; // Start latency pipe
   logic [LOOP_W-1:0] seg_cnt_ff; // Segment repetitions done
   logic [LOOP_W-1:0] seq_cnt_ff; // Sequence passes done
   logic restart; // Start a fresh waveform
   logic step_adv; // Move to next sequence step

   // Address decode
   logic wr_ctrl;
   logic wr_idle;
   logic wr_wloop;
   logic wr_sloop;
   logic wr_cmd;
   assign wr_ctrl = i_wr && (i_addr == A_CTRL);
   assign wr_idle = i_wr && (i_addr == A_IDLE);
   assign wr_wloop = i_wr && (i_addr == A_WLOOP);
   assign wr_sloop = i_wr && (i_addr == A_SLOOP);
   assign wr_cmd = i_wr && (i_addr == A_CMD);

   // Remote command pulses
   logic bus_en;
   logic bus_trig;
   logic bus_abort;
   assign bus_en = wr_cmd && i_wdata[CMD_EN];
   assign bus_trig = wr_cmd && i_wdata[CMD_TRIG];
   assign bus_abort = wr_cmd && i_wdata[CMD_ABORT];

   // Control fields
   logic trig_mode;
   logic armed;
   logic out_on;
   logic [2:0] func;
   logic [1:0] adv;
   logic [1:0] ensrc;
   logic [1:0] insrc;
   logic [1:0] pol;
   assign trig_mode = ctrl_ff[CTL_TRIG];
   assign armed = ctrl_ff[CTL_ARMED];
   assign out_on = ctrl_ff[CTL_OUT_ON];
   assign func = ctrl_ff[CTL_FUNC +: 3];
   assign adv = ctrl_ff[CTL_ADV +: 2];
   assign ensrc = ctrl_ff[CTL_ENSRC +: 2];
   assign insrc = ctrl_ff[CTL_INSRC +: 2];
   assign pol = ctrl_ff[CTL_POL +: 2];

   // Function classes
   logic is_seq;
   logic burst_fn;
   logic [1:0] eff_adv;
   assign is_seq = (func == FN_SEQ) || (func == FN_ADV);
   assign burst_fn = (func == FN_STD) || (func == FN_ARB);
   // Other functions run as if automatic
   assign eff_adv = is_seq ? adv : ADV_AUTO;

   // Transition detectors; event line has no both-edge option
   logic trig_pulse;
   logic evt_pulse;
   awg_edge_detect u_trig_edge (
      .i_sys_clk(i_sys_clk),
      .i_srst(i_srst),
      .i_level(i_trig_in),
      .i_rise_en(pol != POL_FALL),
      .i_fall_en(pol != POL_RISE),
      .o_pulse(trig_pulse)
   );
   awg_edge_detect u_evt_edge (
      .i_sys_clk(i_sys_clk),
      .i_srst(i_srst),
      .i_level(i_event_in),
      .i_rise_en(~ctrl_ff[CTL_EVT_FALL]),
      .i_fall_en(ctrl_ff[CTL_EVT_FALL]),
      .o_pulse(evt_pulse)
   );

   // Source selection; at most one source counts
   logic en_accept;
   logic init_accept;
   logic abort_hit;
   assign en_accept = ((ensrc == EN_TRIG) && trig_pulse) ||
                      ((ensrc == EN_EVENT) && evt_pulse) ||
                      ((ensrc == EN_BUS) && bus_en);
   assign init_accept = ((insrc == IN_PANEL) && i_manual_trigger_button) ||
                        ((insrc == IN_EVENT) && evt_pulse) ||
                        ((insrc == IN_TRIG) && trig_pulse) ||
                        ((insrc == IN_BUS) && bus_trig);
   // Self-armed continuous output ignores abort, as on the bench
   assign abort_hit = trig_mode ? bus_abort :
      (armed && (ctrl_ff[CTL_ABT_BUS] ? bus_abort : i_panel_abort));

   // Start request; one at a time so no trigger is doubled
   logic pending;
   logic start_raw;
   logic start_go;
   logic wait_start;
   assign pending = |lat_ff;
   assign wait_start = (state_ff == ST_IDLE) || (state_ff == ST_HOLD);
   assign start_raw = out_on && wait_start && !pending && !abort_hit &&
      (trig_mode ? init_accept : en_accept);
   assign start_go = lat_ff[LAT_CYC-1];

   // Latency pipe; abort or power-off drops a start in flight
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst || abort_hit || !out_on)
         lat_ff <= '0;
      else
         lat_ff <= (lat_ff << 1) | LAT_CYC'(start_raw);
   end

   // Loop completion
   logic [LOOP_W-1:0] sloop_eff;
   logic seg_done;
   logic seq_done;
   logic step_wait;
   assign sloop_eff = (func == FN_ADV) ? sloop_ff : LOOP_MIN;
   assign seg_done = i_wave_end && (seg_cnt_ff + LOOP_MIN >= wloop_ff);
   assign seq_done = is_seq && i_seq_end &&
      (seq_cnt_ff + LOOP_MIN >= sloop_eff);
   assign step_wait = ctrl_ff[CTL_JUMP] || (eff_adv == ADV_STEP);

   // Run state transitions
   always_comb
   begin
      nxt_state = state_ff;
      restart = 1'b0;
      step_adv = 1'b0;
      if (!out_on)
         nxt_state = ST_OFF;
      // Abort returns to idle and demands a new start
      else if (abort_hit && (state_ff != ST_OFF))
         nxt_state = ST_IDLE;
      else
         case (state_ff)
            ST_OFF:
            begin
               // Self-armed continuous starts with no enable
               if (!trig_mode && !armed)
               begin
                  nxt_state = ST_RUN;
                  restart = 1'b1;
               end
               else
                  nxt_state = ST_IDLE;
            end
            ST_IDLE, ST_HOLD:
            begin
               if (start_go)
               begin
                  nxt_state = ST_RUN;
                  restart = 1'b1;
               end
            end
            ST_RUN:
            begin
               if (is_seq && seq_done)
               begin
                  // Whole sequence done
                  if (trig_mode || (eff_adv == ADV_ONCE))
                     nxt_state = ST_HOLD;
                  else
                     restart = 1'b1;
               end
               else if (is_seq && seg_done)
               begin
                  // Step done: jump now or wait for event
                  if (step_wait)
                     nxt_state = ST_JUMP;
                  else
                     step_adv = 1'b1;
               end
               // Burst length for std/arb, one cycle otherwise
               else if (trig_mode && !is_seq &&
                        (burst_fn ? seg_done : i_wave_end))
                  nxt_state = ST_HOLD;
            end
            ST_JUMP:
            begin
               if (evt_pulse)
               begin
                  nxt_state = ST_RUN;
                  step_adv = 1'b1;
               end
            end
            default:
               nxt_state = ST_OFF;
         endcase
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
         state_ff <= ST_OFF;
      else
         state_ff <= nxt_state;
   end

   // Loop counters cleared on every fresh step or pass
   logic seg_clr;
   logic seq_clr;
   logic in_play;
   assign in_play = (state_ff == ST_RUN) || (state_ff == ST_JUMP);
   assign seg_clr = (state_ff != ST_RUN) || step_adv || seg_done || seq_done;
   assign seq_clr = !in_play || seq_done;

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst || seg_clr)
         seg_cnt_ff <= '0;
      else if (i_wave_end)
         seg_cnt_ff <= seg_cnt_ff + LOOP_MIN;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst || seq_clr)
         seq_cnt_ff <= '0;
      else if (i_seq_end)
         seq_cnt_ff <= seq_cnt_ff + LOOP_MIN;
   end

   // Loop writes clamp to the legal one to one million range
   function automatic logic [LOOP_W-1:0] clamp_loop(
      input logic [DATA_W-1:0] v);
      if (v == '0)
         return LOOP_MIN;
      else if (v > DATA_W'(LOOP_MAX))
         return LOOP_MAX;
      else
         return v[LOOP_W-1:0];
   endfunction : clamp_loop

   // Front panel may only drop the armed bit, never set it
   logic [DATA_W-1:0] ctrl_src;
   logic [DATA_W-1:0] nxt_ctrl;
   assign ctrl_src = wr_ctrl ? i_wdata : ctrl_ff;
   assign nxt_ctrl = ctrl_src &
      ~({{(DATA_W-1){1'b0}}, i_panel_self_arm} << CTL_ARMED);

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         ctrl_ff <= CTRL_RST;
         idle_ff <= IDLE_RST;
         wloop_ff <= LOOP_MIN;
         sloop_ff <= LOOP_MIN;
      end
      else
      begin
         ctrl_ff <= nxt_ctrl;
         if (wr_idle)
            idle_ff <= i_wdata[IDLE_W-1:0];
         if (wr_wloop)
            wloop_ff <= clamp_loop(i_wdata);
         if (wr_sloop)
            sloop_ff <= clamp_loop(i_wdata);
      end
   end

   // Read mux; unmapped and command addresses read zero
   logic [DATA_W-1:0] stat_word;
   logic [DATA_W-1:0] rd_mux;
   assign stat_word = {seg_cnt_ff, 8'h00, pending, state_ff};
   assign rd_mux =
      (i_addr == A_CTRL)  ? ctrl_ff :
      (i_addr == A_IDLE)  ? {{(DATA_W-IDLE_W){1'b0}}, idle_ff} :
      (i_addr == A_WLOOP) ? {{(DATA_W-LOOP_W){1'b0}}, wloop_ff} :
      (i_addr == A_SLOOP) ? {{(DATA_W-LOOP_W){1'b0}}, sloop_ff} :
      (i_addr == A_STAT)  ? stat_word : '0;

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst || !i_rd)
         o_rdata <= '0;
      else
         o_rdata <= rd_mux;
   end

   // Engine controls; run, hold and idle decoded from the state flop
   assign o_gen_run = in_play;
   assign o_hold_last = (state_ff == ST_HOLD);
   assign o_idle_active = (state_ff == ST_IDLE);
   assign o_idle_level = idle_ff;
   assign o_wave_restart = restart;
   assign o_step_adv = step_adv;
   assign o_smart_permit = trig_mode && ctrl_ff[CTL_SMART];

   // Checks
   a_arm_remote_only: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      $rose(armed) |-> $past(wr_ctrl))
      else $error("armed bit set without a bus write");
   a_armed_waits: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (state_ff == ST_IDLE) && !start_go |=> state_ff != ST_RUN)
      else $error("left idle without a start");
   a_cont_keeps: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (state_ff == ST_RUN) && !trig_mode && !is_seq && !abort_hit &&
      out_on && !wr_ctrl |=> state_ff == ST_RUN)
      else $error("continuous output stopped without abort");
   a_self_starts: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (state_ff == ST_OFF) && out_on && !trig_mode && !armed && !wr_ctrl
      |=> o_gen_run)
      else $error("self-armed output did not start");
   a_bus_src_only: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      !trig_mode && (ensrc == EN_BUS) && !bus_en |-> !start_raw)
      else $error("enable taken from a disabled input");
   a_jump_holds: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (state_ff == ST_JUMP) && !evt_pulse && !abort_hit && out_on
      |=> state_ff == ST_JUMP)
      else $error("step jumped without an event");
   a_start_latency: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      start_raw ##1 (!abort_hit && out_on)[*2] |-> o_wave_restart)
      else $error("start latency wrong");
   a_one_cycle: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (state_ff == ST_RUN) && trig_mode && !is_seq && !burst_fn &&
      i_wave_end && !abort_hit && out_on |=> o_hold_last)
      else $error("no hold after single triggered cycle");
   a_trig_abort_bus: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      trig_mode && (state_ff == ST_HOLD) && !bus_abort && !start_go &&
      out_on && !wr_ctrl |=> state_ff == ST_HOLD)
      else $error("triggered output left hold without cause");
   a_loop_range: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (wloop_ff >= LOOP_MIN) && (wloop_ff <= LOOP_MAX))
      else $error("segment loop count out of range");

   c_armed_start: cover property (@(posedge i_sys_clk)
      (state_ff == ST_IDLE) && !trig_mode ##1 o_wave_restart);
   c_burst_hold: cover property (@(posedge i_sys_clk)
      burst_fn && seg_done && trig_mode ##1 o_hold_last);
   c_jump_event: cover property (@(posedge i_sys_clk)
      (state_ff == ST_JUMP) && evt_pulse);
endmodule : awg_run_ctrl
`default_nettype wire

// ===== bench/awg_engine_model.sv
// Behavioural waveform engine beside the controller's far side
`timescale 1ns/1ps
`default_nettype none
module awg_engine_model #(
   parameter int WAVE_CYC = 4
)(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_srst,
   // Controller requests
   input wire logic i_gen_run,
   input wire logic i_wave_restart,
   // Progress pulses
   output logic o_wave_end,
   output logic o_seq_end
);
   logic [7:0] phase_ff; // Cycle within the current waveform
   logic pass_ff; // Second waveform of a two-waveform pass
   logic last; // Final cycle of a waveform
   assign last = (phase_ff == 8'(WAVE_CYC - 1));
   // Counts only while generating, so a held output sees no end pulses
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst || i_wave_restart || !i_gen_run)
      begin
         phase_ff <= 8'h00;
         pass_ff <= 1'b0;
         o_wave_end <= 1'b0;
         o_seq_end <= 1'b0;
      end
      else
      begin
         phase_ff <= last ? 8'h00 : phase_ff + 8'h01;
         pass_ff <= pass_ff ^ last;
         o_wave_end <= last;
         o_seq_end <= last & pass_ff;
      end
   end
endmodule : awg_engine_model
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the run, arm and trigger controller
`timescale 1ns/1ps
`default_nettype none
module tb;
   import awg_run_pkg::*;
   localparam int LAT = 2; // Start latency under test
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [ADDR_W-1:0] addr = 8'h00;
   logic [DATA_W-1:0] wdata = 32'h0;
   logic wr = 1'b0, rd = 1'b0;
   logic self_arm = 1'b0, btn = 1'b0, pab = 1'b0;
   logic trig = 1'b0, evt = 1'b0;
   logic wave_end, seq_end;
   logic [DATA_W-1:0] o_rdata;
   logic o_gen_run, o_hold_last, o_idle_active, o_wave_restart;
   logic o_step_adv, o_smart_permit;
   logic [IDLE_W-1:0] o_idle_level;
   int err_total = 0;
   int compares = 0;
   // Reset table: addresses and values, last one unmapped
   localparam logic [ADDR_W-1:0] RA [6] =
      '{A_CTRL, A_IDLE, A_WLOOP, A_SLOOP, A_CMD, 8'h20};
   localparam logic [DATA_W-1:0] RV [6] = '{0, 0, 1, 1, 0, 0};
   // Clock at 20 MHz
   always #25 clk = ~clk;
   awg_run_ctrl #(.LAT_CYC(LAT)) i_dut (.i_sys_clk(clk), .i_srst(srst),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(o_rdata), .i_panel_self_arm(self_arm),
      .i_manual_trigger_button(btn), .i_panel_abort(pab),
      .i_trig_in(trig), .i_event_in(evt), .i_wave_end(wave_end),
      .i_seq_end(seq_end), .o_gen_run(o_gen_run),
      .o_hold_last(o_hold_last), .o_idle_active(o_idle_active),
      .o_idle_level(o_idle_level), .o_wave_restart(o_wave_restart),
      .o_step_adv(o_step_adv), .o_smart_permit(o_smart_permit));
   awg_engine_model #(.WAVE_CYC(4)) i_eng (.i_sys_clk(clk),
      .i_srst(srst), .i_gen_run(o_gen_run),
      .i_wave_restart(o_wave_restart), .o_wave_end(wave_end),
      .o_seq_end(seq_end));
   // Verdict and end of run
   task automatic print_verdict();
      if (err_total == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   // One comparison
   task automatic chk(input bit ok, input string msg);
      compares++;
      if (!ok)
      begin
         err_total++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask : chk
   // Register write
   task automatic wr_reg(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   // Register read, data taken in the following cycle
   task automatic rd_reg(input logic [ADDR_W-1:0] a,
      output logic [DATA_W-1:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = o_rdata;
   endtask : rd_reg
   // Start request: 0 trigger line, 1 event, 2 bus, 3 manual button
   task automatic fire(input int k);
      @(posedge clk);
      case (k)
         0: trig <= ~trig;
         1: evt <= 1'b1;
         2:
         begin
            addr <= A_CMD;
            wdata <= 32'h3; // Enable and trigger command bits
            wr <= 1'b1;
         end
         default: btn <= 1'b1;
      endcase
      @(posedge clk);
      wr <= 1'b0;
      btn <= 1'b0;
   endtask : fire
   // Panel abort pulse
   task automatic panel_abort();
      @(posedge clk);
      pab <= 1'b1;
      @(posedge clk);
      pab <= 1'b0;
   endtask : panel_abort
   // Return both lines low on a clock edge
   task automatic drop_lines();
      @(posedge clk);
      trig <= 1'b0;
      evt <= 1'b0;
   endtask : drop_lines
   // Run level must stay as given for eight cycles
   task automatic watch(input logic exp_run, input string msg);
      bit bad;
      bad = 0;
      repeat (8)
      begin
         @(negedge clk);
         if (o_gen_run !== exp_run)
            bad = 1;
      end
      chk(!bad, msg);
   endtask : watch
   // Cycles from the end of a request to the restart pulse
   task automatic wait_start(output int n);
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (o_wave_restart !== 1'b1 && n < 20);
   endtask : wait_start
   // Source code to request kind
   function automatic int kind_of(input bit tm, input int src);
      if (!tm)
         return src;
      return (src == 0) ? 3 : (src == 1) ? 1 : (src == 2) ? 0 : 2;
   endfunction : kind_of
   // Hang guard, far beyond the expected run
   initial
   begin
      #(30000 * 50);
      err_total++;
      print_verdict();
   end
   // Main sequence
   initial
   begin : main
      logic [DATA_W-1:0] v, c;
      int n, lat0, cnt, kd, wl, src, fn;
      lat0 = -1;
      void'($urandom(55492));
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      for (int k = 0; k < 6; k++)
      begin
         rd_reg(RA[k], v);
         chk(v === RV[k], "reset value");
      end
      // Loop counts clamp at both ends
      for (int k = 0; k < 2; k++)
      begin
         wr_reg(k ? A_SLOOP : A_WLOOP, 32'h0);
         rd_reg(k ? A_SLOOP : A_WLOOP, v);
         chk(v[LOOP_W-1:0] === LOOP_MIN, "loop low clamp");
         wr_reg(k ? A_SLOOP : A_WLOOP, 32'hfffff);
         rd_reg(k ? A_SLOOP : A_WLOOP, v);
         chk(v[LOOP_W-1:0] === LOOP_MAX, "loop high clamp");
      end
      // Panel can only leave the armed setting
      wr_reg(A_CTRL, 32'h2);
      @(posedge clk);
      self_arm <= 1'b1;
      @(posedge clk);
      self_arm <= 1'b0;
      rd_reg(A_CTRL, v);
      chk(v[CTL_ARMED] === 1'b0, "panel self-arm");
      wr_reg(A_CTRL, 32'h0001_0000);
      repeat (LAT + 4) @(negedge clk);
      chk(o_gen_run === 1'b1 && o_idle_active === 1'b0, "self-armed");
      // Continuous armed, each enable source
      for (src = 0; src < 3; src++)
      begin
         wr_reg(A_CTRL, 32'h0);
         v = $urandom;
         wr_reg(A_IDLE, v);
         c = 32'h0001_8002;
         c[CTL_ENSRC +: 2] = 2'(src);
         c[CTL_ABT_BUS] = (src == 2);
         c[CTL_ADV +: 2] = 2'($urandom % 3);
         wr_reg(A_CTRL, c);
         repeat (2) @(negedge clk);
         chk(o_idle_active === 1'b1, "idle");
         chk(o_idle_level === v[IDLE_W-1:0], "idle level");
         chk(o_smart_permit === 1'b0, "smart off");
         kd = kind_of(0, src);
         for (int k = 0; k < 4; k++)
            if (k != kd)
            begin
               fire(k);
               watch(1'b0, "foreign enable");
               drop_lines();
            end
         fire(kd);
         wait_start(n);
         drop_lines();
         if (lat0 < 0)
            lat0 = n;
         chk(n === lat0 && n >= 1 && n <= LAT + 1, "latency");
         watch(1'b1, "keeps running");
         if (src == 2)
         begin
            panel_abort();
            watch(1'b1, "wrong abort");
            wr_reg(A_CMD, 32'h4);
         end
         else
            panel_abort();
         repeat (2) @(negedge clk);
         chk(o_idle_active === 1'b1 && o_gen_run === 1'b0, "abort");
         watch(1'b0, "waits after abort");
         fire(kd);
         wait_start(n);
         chk(n === lat0, "re-enable");
         drop_lines();
      end
      // Triggered: each initiate source, then falling and both polarity
      for (int i = 0; i < 6; i++)
      begin
         wr_reg(A_CTRL, 32'h0);
         trig <= (i == 4);
         wl = 1 + $urandom % 3;
         wr_reg(A_WLOOP, wl);
         src = (i < 4) ? i : 2;
         c = 32'h0001_8001;
         fn = $urandom % 4; // Std, arb, mod or pulse
         c[CTL_FUNC +: 3] = 3'((fn < 2) ? fn : fn + 2);
         if (fn > 1)
            wl = 1; // Mod and pulse play a single cycle
         c[CTL_INSRC +: 2] = 2'(src);
         c[CTL_POL +: 2] = (i == 4) ? POL_FALL :
            (i == 5) ? POL_BOTH : POL_RISE;
         wr_reg(A_CTRL, c);
         repeat (2) @(negedge clk);
         chk(o_idle_active === 1'b1, "armed idle");
         chk(o_smart_permit === 1'b1, "smart on");
         kd = kind_of(1, src);
         for (int k = 0; k < 4; k++)
            if (k != kd && i < 4)
            begin
               fire(k);
               watch(1'b0, "foreign initiate");
               drop_lines();
            end
         fire(kd);
         wait_start(n);
         chk(n === lat0, "trigger latency");
         drop_lines();
         cnt = 0;
         for (int t = 0; t < 200 && o_hold_last !== 1'b1; t++)
         begin
            @(negedge clk);
            if (wave_end === 1'b1 && o_hold_last !== 1'b1)
               cnt++;
         end
         chk(cnt === wl && o_gen_run === 1'b0, "burst count");
         chk(o_hold_last === 1'b1, "hold last");
         panel_abort();
         repeat (2) @(negedge clk);
         chk(o_hold_last === 1'b1, "panel abort ignored");
         wr_reg(A_CMD, 32'h4);
         repeat (2) @(negedge clk);
         chk(o_idle_active === 1'b1, "bus abort");
         drop_lines();
      end
      // Sequenced step with jump flag parks until an event edge
      wr_reg(A_CTRL, 32'h0);
      wr_reg(A_WLOOP, 32'h1);
      wr_reg(A_CTRL, 32'h0003_0008);
      repeat (12) @(posedge clk);
      rd_reg(A_STAT, v);
      chk(v[3:0] === 4'h4, "jump wait");
      @(posedge clk);
      evt <= 1'b1;
      @(negedge clk);
      chk(o_step_adv === 1'b1, "jump event");
      drop_lines();
      print_verdict();
   end
endmodule : tb
`default_nettype wire
